// ---- logic/pcl_pkg.sv ----
// Package: image word addresses, config field positions, defaults, types
package pcl_pkg;
   // Image word addresses (16-bit word index into the startup image)
   localparam logic [7:0] IMG_P3_LINK   = 8'h46;
   localparam logic [7:0] IMG_PM_BASE   = 8'h50;
   localparam logic [7:0] IMG_SLOT_P0   = 8'h60;
   localparam logic [7:0] IMG_SLOT_P1   = 8'h62;
   localparam logic [7:0] IMG_LAST      = 8'h62;
   // Configuration offsets
   localparam logic [11:0] CFG_PMCAP    = 12'h040;
   localparam logic [11:0] CFG_PMCSR    = 12'h044;
   localparam logic [11:0] CFG_LINKCTL  = 12'h078;
   localparam logic [11:0] CFG_DCHG     = 12'h08C;
   localparam logic [11:0] CFG_PCIECAP  = 12'h0C0;
   localparam logic [11:0] CFG_PORTNUM  = 12'h0CC;
   localparam logic [11:0] CFG_SLOTCLK  = 12'h0D0;
   localparam logic [11:0] CFG_DEEMPH   = 12'h0F0;
   localparam logic [11:0] CFG_VCCAP    = 12'h144;
   localparam logic [11:0] CFG_TCMAP    = 12'h154;
   // Config field positions
   localparam int DEEMPH_POS   = 6;
   localparam int COMPL_POS    = 11;
   localparam int DCHG_LSB     = 8;
   localparam int NSR_POS      = 3;
   localparam int AUX_LSB      = 22;
   localparam int DSI_POS      = 21;
   localparam int D1_POS       = 25;
   localparam int D2_POS       = 26;
   localparam int PME_LSB      = 28;
   localparam int PMDATA_LSB   = 24;
   localparam int SLOTCLK_POS  = 28;
   localparam int LOW_PRIORITY_VC_COUNT_POS     = 4;
   localparam int PORTNUM_LSB  = 24;
   localparam int TCMAP_LSB    = 1;
   localparam int SLOTIMP_POS  = 24;
   // Image bit positions
   localparam int IB_DEEMPH    = 12;
   localparam int IB_COMPL     = 13;
   localparam int IB_DCHG      = 14;
   localparam int IB_NSR       = 0;
   localparam int IB_AUX       = 1;
   localparam int IB_PME       = 6;
   localparam int IB_PMDATA    = 8;
   localparam int IB_SLOTIMP   = 0;
   localparam int IB_SLOTCLK   = 1;
   localparam int IB_DSI       = 2;
   localparam int IB_LOW_PRIORITY_VC_COUNT      = 3;
   localparam int IB_PORTNUM   = 4;
   localparam int IB_TCMAP     = 9;
   // Reset defaults of loadable fields
   localparam logic [15:0] DEF_WORD     = 16'h0000;
   localparam logic [2:0]  DEF_PORTNUM0 = 3'h0;
   localparam int          NUM_PORTS    = 4;

   // Per-port loaded fields
   typedef struct packed {
      logic       deemph;
      logic       compl2det;
      logic [1:0] dataChangeCountSelect;
      logic       noSoftReset;
      logic [2:0] auxCurrent;
      logic       dsiRequired;
      logic [1:0] pmeSupport;
      logic [7:0] pmData;
      logic       slotClock;
      logic       lowPriorityVcCount;
      logic [2:0] portNumber;
      logic [6:0] tcMap;
      logic       slotImpl;
   } pcl_port_cfg_t;

   // Image read request and answer
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
   } pcl_img_req_t;

   typedef struct packed {
      logic        valid;
      logic        present;
      logic [15:0] data;
   } pcl_img_rsp_t;
endpackage

// ---- logic/pcl_word_apply.sv ----
// Applies one image word to the per-port field set
module pcl_word_apply (
   input  wire logic [7:0]            wordAddr,
   input  wire logic [15:0]           wordData,
   input  wire pcl_pkg::pcl_port_cfg_t curCfg [pcl_pkg::NUM_PORTS],
   output      pcl_pkg::pcl_port_cfg_t newCfg [pcl_pkg::NUM_PORTS]
);
   // Decode word address into field updates
   always_comb begin
      for (int p = 0; p < pcl_pkg::NUM_PORTS; p++) begin
         newCfg[p] = curCfg[p];
      end
      case (wordAddr)
         pcl_pkg::IMG_P3_LINK: begin
            newCfg[3].deemph = wordData[pcl_pkg::IB_DEEMPH];     // R1
            newCfg[3].compl2det = wordData[pcl_pkg::IB_COMPL];   // R2
            newCfg[3].dataChangeCountSelect =
               wordData[pcl_pkg::IB_DCHG +: 2];                   // R3
         end
         pcl_pkg::IMG_SLOT_P0, pcl_pkg::IMG_SLOT_P1: begin
            // Port 0 from 60h, port 1 from 62h
            for (int p = 0; p < 2; p++) begin
               if (wordAddr == (p == 0 ? pcl_pkg::IMG_SLOT_P0
                                       : pcl_pkg::IMG_SLOT_P1)) begin // R16
                  newCfg[p].slotClock = wordData[pcl_pkg::IB_SLOTCLK]; // R10
                  newCfg[p].dsiRequired = wordData[pcl_pkg::IB_DSI];   // R11
                  newCfg[p].lowPriorityVcCount =
                     wordData[pcl_pkg::IB_LOW_PRIORITY_VC_COUNT];                     // R12
                  newCfg[p].portNumber =
                     wordData[pcl_pkg::IB_PORTNUM +: 3];             // R13
                  newCfg[p].tcMap = wordData[pcl_pkg::IB_TCMAP +: 7]; // R14
               end
            end
            if (wordAddr == pcl_pkg::IMG_SLOT_P1) begin
               newCfg[1].slotImpl = wordData[pcl_pkg::IB_SLOTIMP]; // R15
            end
         end
         default: begin
            // PM words: even word caps, odd word data, one pair per port
            for (int p = 0; p < pcl_pkg::NUM_PORTS; p++) begin
               if (wordAddr == pcl_pkg::IMG_PM_BASE + 8'(2 * p)) begin
                  newCfg[p].noSoftReset = wordData[pcl_pkg::IB_NSR]; // R4
                  newCfg[p].auxCurrent = wordData[pcl_pkg::IB_AUX +: 3]; // R5
                  newCfg[p].pmeSupport = wordData[pcl_pkg::IB_PME +: 2]; // R8
               end
               if (wordAddr == pcl_pkg::IMG_PM_BASE + 8'(2 * p + 1)) begin
                  newCfg[p].pmData =
                     wordData[pcl_pkg::IB_PMDATA +: 8];               // R9
               end
            end
         end
      endcase
   end
endmodule // pcl_word_apply

// ---- logic/pcl_cfg_read.sv ----
// Assembles the 32-bit config dword of one port at one offset
module pcl_cfg_read (
   input  wire logic [11:0]            offset,
   input  wire pcl_pkg::pcl_port_cfg_t cfg,
   output      logic [31:0]            dword
);
   // Place loaded fields at their config bit positions
   always_comb begin
      dword = 32'h0000_0000;
      case (offset)
         pcl_pkg::CFG_PMCAP: begin
            dword[pcl_pkg::AUX_LSB +: 3] = cfg.auxCurrent;    // R5
            dword[pcl_pkg::DSI_POS] = cfg.dsiRequired;        // R11
            dword[pcl_pkg::D1_POS] = 1'b1;                    // R6
            dword[pcl_pkg::D2_POS] = 1'b1;                    // R7
            dword[pcl_pkg::PME_LSB +: 2] = cfg.pmeSupport;    // R8
         end
         pcl_pkg::CFG_PMCSR: begin
            dword[pcl_pkg::NSR_POS] = cfg.noSoftReset;          // R4
            dword[pcl_pkg::PMDATA_LSB +: 8] = cfg.pmData;       // R9
         end
         pcl_pkg::CFG_LINKCTL: dword[pcl_pkg::COMPL_POS] = cfg.compl2det;
         pcl_pkg::CFG_DCHG:
            dword[pcl_pkg::DCHG_LSB +: 2] = cfg.dataChangeCountSelect;
         pcl_pkg::CFG_PCIECAP: dword[pcl_pkg::SLOTIMP_POS] = cfg.slotImpl;
         pcl_pkg::CFG_PORTNUM:
            dword[pcl_pkg::PORTNUM_LSB +: 3] = cfg.portNumber;
         pcl_pkg::CFG_SLOTCLK: dword[pcl_pkg::SLOTCLK_POS] = cfg.slotClock;
         pcl_pkg::CFG_DEEMPH: dword[pcl_pkg::DEEMPH_POS] = cfg.deemph;
         pcl_pkg::CFG_VCCAP: dword[pcl_pkg::LOW_PRIORITY_VC_COUNT_POS] = cfg.lowPriorityVcCount;
         pcl_pkg::CFG_TCMAP: dword[pcl_pkg::TCMAP_LSB +: 7] = cfg.tcMap;
         default: dword = 32'h0000_0000;
      endcase
   end
endmodule // pcl_cfg_read

// ---- logic/pcl_loader.sv ----
// Top: startup image loader with APB read-back of per-port config fields
// What this block does
// (R1) Port 3 de-emphasis from image bit 12
// (R2) Port 3 compliance-to-detect from bit 13
// (R3) Port 3 change count select from 15:14
// (R4) No-soft-reset bit from words 50h..56h
// (R5) Aux current from image bits 3:1
// (R6) D1 support reads as one
// (R7) D2 support reads as one
// (R8) PME D1/D2 support from bits 7:6
// (R9) PM data from odd words 51h..57h
// (R10) Slot clock from image bit 1
// (R11) Device-specific init from image bit 2
// (R12) Low-priority VC count from bit 3
// (R13) Logical port number from bits 6:4
// (R14) TC to VC0 map from bits 15:9
// (R15) Port 1 slot implemented from 62h
// (R16) Ports 0/1 slot fields from 60h/62h
// (R17) Load all first; absent words keep defaults
module pcl_loader (
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   // Image source: request out, answer in
   output      pcl_pkg::pcl_img_req_t imgReq,
   input  wire pcl_pkg::pcl_img_rsp_t imgRsp,
   // APB slave; address = port * 1000h + config offset
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [13:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   // Loading finished
   output      logic                  loadDone
);
   typedef enum {PCL_FETCH, PCL_WAIT, PCL_DONE} pcl_state_t;

   pcl_state_t             state;               // Loader state
   logic [7:0]             wordAddr;            // Current image word
   pcl_pkg::pcl_port_cfg_t cfg [pcl_pkg::NUM_PORTS];  // Loaded fields
   pcl_pkg::pcl_port_cfg_t next_cfg [pcl_pkg::NUM_PORTS]; // After apply
   pcl_pkg::pcl_port_cfg_t selCfg;              // Port picked by paddr
   logic [31:0]            rdWord;              // Assembled read dword
   logic [1:0]             selPort;             // Port field of paddr
   logic                   accessPhase;         // APB access cycle

   // Address walk of the image: next word to fetch
   function automatic logic [7:0] pcl_next_word(input logic [7:0] a);
      logic [7:0] r;
      r = a + 8'h01;
      if (a == pcl_pkg::IMG_P3_LINK) r = pcl_pkg::IMG_PM_BASE;
      else if (a == pcl_pkg::IMG_PM_BASE + 8'h07) r = pcl_pkg::IMG_SLOT_P0;
      else if (a == pcl_pkg::IMG_SLOT_P0) r = pcl_pkg::IMG_SLOT_P1;
      return r;
   endfunction

   // Field update for the word now answered
   pcl_word_apply u_apply (
      .wordAddr (wordAddr),
      .wordData (imgRsp.data),
      .curCfg   (cfg),
      .newCfg   (next_cfg)
   );

   assign selPort = paddr[13:12];
   assign selCfg  = cfg[selPort];
   assign accessPhase = psel && penable;

   // Read mux for the addressed port
   pcl_cfg_read u_read (
      .offset (paddr[11:0]),
      .cfg    (selCfg),
      .dword  (rdWord)
   );

   // Loader sequencer: one outstanding read, then next word
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state    <= PCL_FETCH;
         wordAddr <= pcl_pkg::IMG_P3_LINK;
         imgReq   <= '0;
      end else begin
         case (state)
            PCL_FETCH: begin
               imgReq.valid <= 1'b1;
               imgReq.addr  <= wordAddr;
               state        <= PCL_WAIT;
            end
            PCL_WAIT: begin
               imgReq.valid <= 1'b0;
               if (imgRsp.valid) begin
                  // Last word ends the load
                  if (wordAddr == pcl_pkg::IMG_LAST) begin
                     state <= PCL_DONE;                         // R17
                  end else begin
                     wordAddr <= pcl_next_word(wordAddr);
                     state    <= PCL_FETCH;
                  end
               end
            end
            PCL_DONE: imgReq.valid <= 1'b0;
            default:  state <= PCL_FETCH;
         endcase
      end
   end

   // Field storage; an absent word leaves the defaults untouched
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int p = 0; p < pcl_pkg::NUM_PORTS; p++) begin
            cfg[p] <= '0;
            cfg[p].portNumber <= pcl_pkg::DEF_PORTNUM0 + 3'(p);
         end
      end else if (state == PCL_WAIT && imgRsp.valid &&
                   imgRsp.present) begin
         cfg <= next_cfg;                                        // R17
      end
   end

   // Done flag gates host config access
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         loadDone <= 1'b0;
      end else begin
         loadDone <= (state == PCL_DONE);
      end
   end

   // APB answer: held off until load finished, one wait state then
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         if (accessPhase && !pready && loadDone) begin          // R17
            pready <= 1'b1;
            // Fields are read only; writes are refused with an error
            pslverr <= pwrite;
            prdata  <= pwrite ? 32'h0000_0000 : rdWord;
         end
      end
   end
endmodule // pcl_loader

// ---- verification/pcl_img_model.sv ----
// Behavioural image store that answers the loader's word requests
module pcl_img_model (
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   input  wire pcl_pkg::pcl_img_req_t imgReq,
   output      pcl_pkg::pcl_img_rsp_t imgRsp,
   input  wire logic [7:0]            absentAddr,
   input  wire logic [3:0]            lat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy;  // A request is outstanding
   logic [3:0] cnt;   // Idle cycles left before the answer
   logic [7:0] addrQ; // Word being fetched
   // Word contents: a fixed mix of the word index
   function automatic logic [15:0] img(input logic [7:0] a);
      return {a ^ 8'hE7, ~a};
   endfunction
   // Answer after lat idle cycles; data toggles between answers
   // so the loader cannot rely on stale values
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         busy   <= 1'b0;
         cnt    <= 4'h0;
         addrQ  <= 8'h00;
         imgRsp <= '0;
      end else begin
         imgRsp.valid <= 1'b0;
         imgRsp.data  <= ~imgRsp.data;
         if (imgReq.valid) begin
            busy  <= 1'b1;
            cnt   <= lat;
            addrQ <= imgReq.addr;
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy           <= 1'b0;
            imgRsp.valid   <= 1'b1;
            imgRsp.present <= (addrQ != absentAddr);
            imgRsp.data    <= img(addrQ);
         end
      end
   end
endmodule // pcl_img_model

// ---- verification/pcl_loader_props.sv ----
// Checker of the loader's port behaviour, bound to the loader top
module pcl_loader_props (
   input wire logic                  clk_sys,
   input wire logic                  rstn,
   input wire pcl_pkg::pcl_img_req_t imgReq,
   input wire pcl_pkg::pcl_img_rsp_t imgRsp,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [13:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  loadDone
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   no_early_ack_a: assert property (!loadDone |-> !pready)
      else $error("Bus answered before loading finished");
   write_err_a: assert property (pready && pwrite |-> pslverr)
      else $error("Write not refused");
   read_ok_a: assert property (pready && !pwrite |-> !pslverr)
      else $error("Read flagged as error");
   d1d2_one_a: assert property (pready && !pwrite
      && paddr[11:0] == 12'h040 |-> prdata[26:25] == 2'h3)
      else $error("D1 or D2 support bit reads zero");
   req_pulse_a: assert property (imgReq.valid |=> !imgReq.valid)
      else $error("Image request longer than one cycle");
   ack_lat_a: assert property (psel && penable && loadDone
      && !pready |=> pready)
      else $error("Access not answered on the next edge");
   order_pm_a: assert property (imgRsp.valid && imgReq.addr == 8'h46
      |-> ##[1:2] (imgReq.valid && imgReq.addr == 8'h50))
      else $error("Word 50h not fetched after 46h");
   order_slot_a: assert property (imgRsp.valid && imgReq.addr == 8'h57
      |-> ##[1:2] (imgReq.valid && imgReq.addr == 8'h60))
      else $error("Word 60h not fetched after 57h");
   done_flag_a: assert property (imgRsp.valid && imgReq.addr == 8'h62
      |-> ##[1:2] loadDone)
      else $error("Load not finished after last word");
   cover property (pready && pwrite);
   cover property (imgRsp.valid && !imgRsp.present);
   cover property ($rose(loadDone));
endmodule // pcl_loader_props
bind pcl_loader pcl_loader_props i_props (.*);

// ---- verification/pcl_loader_tb_top.sv ----
// Self-checking bench for the startup image loader
module pcl_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk_sys = 1'b0; // 40 MHz system clock
   logic                  rstn = 1'b0;    // Async reset, active low
   pcl_pkg::pcl_img_req_t imgReq;         // Loader to image store
   pcl_pkg::pcl_img_rsp_t imgRsp;         // Image store answer
   logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [13:0]           paddr = '0;
   logic [31:0]           pwdata = '0, prdata, rd;
   logic                  pready, pslverr, loadDone, err;
   logic [7:0]            absentAddr = 8'hFF; // Word the store lacks
   logic [3:0]            lat = 4'h0;         // Store answer delay
   logic                  absent60 = 1'b0;    // Word 60h expected missing
   int                    n_errors = 0, checks = 0;
   always #12.5 clk_sys = ~clk_sys;
   pcl_loader i_dut (.clk_sys(clk_sys), .rstn(rstn), .imgReq(imgReq),
      .imgRsp(imgRsp), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .loadDone(loadDone));
   pcl_img_model i_img (.clk_sys(clk_sys), .rstn(rstn), .imgReq(imgReq),
      .imgRsp(imgRsp), .absentAddr(absentAddr), .lat(lat));
   // Same word mix as the store, used only to reckon expectations
   function automatic logic [15:0] img(input logic [7:0] a);
      return {a ^ 8'hE7, ~a};
   endfunction
   // Expected dword of port p at offset o; absent words give defaults
   function automatic logic [31:0] expv(input int p, input logic [11:0] o);
      logic [15:0] w3, wa, wb, ws;
      logic [2:0]  pn;
      w3 = (p == 3) ? img(8'h46) : 16'h0;
      wa = img(8'h50 + 8'(2 * p));
      wb = img(8'h51 + 8'(2 * p));
      ws = (p == 1) ? img(8'h62) : (p == 0 && !absent60) ? img(8'h60) : '0;
      pn = (p < 2) ? ws[6:4] : 3'(p);
      case (o)
         12'h040: return {2'h0, wa[7:6], 3'h3, wa[3:1], ws[2], 21'h0};
         12'h044: return {wb[15:8], 20'h0, wa[0], 3'h0};
         12'h078: return {20'h0, w3[13], 11'h0};
         12'h08C: return {22'h0, w3[15:14], 8'h0};
         12'h0F0: return {25'h0, w3[12], 6'h0};
         12'h0C0: return {7'h0, ws[0] & (p == 1), 24'h0};
         12'h0CC: return {5'h0, pn, 24'h0};
         12'h0D0: return {3'h0, ws[1], 28'h0};
         12'h144: return {27'h0, ws[3], 4'h0};
         12'h154: return {24'h0, ws[15:9], 1'h0};
         default: return 32'h0;
      endcase
   endfunction
   // Compare one value, count it, report a mismatch at once
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [13:0] a,
                      output logic [31:0] d, output logic e);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= 32'hFFFF_FFFF;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reset for ten cycles with a given store behaviour
   task automatic reset_dut(input logic [7:0] ab, input logic [3:0] l);
      rstn       <= 1'b0;
      absentAddr <= ab;
      lat        <= l;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
   endtask
   // Read the given offsets of all four ports and compare
   task automatic rd_all(input logic [11:0] offs[$]);
      foreach (offs[i]) begin
         for (int p = 0; p < 4; p++) begin
            apb(1'b0, {2'(p), offs[i]}, rd, err);
            chk(rd, expv(p, offs[i]));
         end
      end
   endtask
   // Prompt store: every loaded field of every port
   task automatic t_load();
      absent60 = 1'b0;
      reset_dut(8'hFF, 4'h0);
      rd_all('{12'h078, 12'h08C, 12'h0F0});
      rd_all('{12'h040, 12'h044});
      rd_all('{12'h0C0, 12'h0CC, 12'h0D0, 12'h144});
      rd_all('{12'h154, 12'h000});
      chk({31'h0, loadDone}, 32'h1);
      $display("Test load done");
   endtask
   // Writes are refused and leave read-only fields unchanged
   task automatic t_write();
      apb(1'b1, 14'h0040, rd, err);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 14'h3044, rd, err);
      chk({31'h0, err}, 32'h1);
      rd_all('{12'h040, 12'h044});
      $display("Test write done");
   endtask
   // Slow store, word 60h missing, access issued during the load
   task automatic t_slow();
      absent60 = 1'b1;
      reset_dut(8'h60, 4'h3);
      apb(1'b0, 14'h00CC, rd, err);
      chk({31'h0, loadDone}, 32'h1);
      chk(rd, expv(0, 12'h0CC));
      rd_all('{12'h040, 12'h0C0, 12'h0D0, 12'h144, 12'h154});
      $display("Test slow done");
   endtask
   // Report counts and the verdict, then end the run
   task automatic stop_test();
      $display("Counts: %0d checks, %0d errors", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      t_load();
      t_write();
      t_slow();
      stop_test();
   end
   // Watchdog: far beyond the few hundred cycles the tests need
   initial begin
      #(25 * 20000);
      n_errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      stop_test();
   end
endmodule // pcl_loader_tb_top
